/* flash_host.sv */
// host controller driving the flash and sram memory through its pins
// Functional notes
// - sector erase: six cycles, last 30H
// - bank erase: six cycles, 10H to 5555H
// - host polls status during program and erase
// - confirm completion with two extra reads
// - program three-cycle unlock, erase six cycles
// - exit command leaves identification mode
`timescale 1ns/1ps
module flash_host
  import flash_host_pkg::*;
#(
  parameter int PROG_TIMEOUT = PROG_MAX_CYC // cycles before a program is declared failed
)(
  input  wire logic        clk,                 // 10 MHz clock
  input  wire logic        rst,                 // asynchronous reset, active high
  input  wire logic        ce,                  // clock enable, freezes state when low
  input  wire logic        req_valid,           // operation request
  output logic             req_ready,           // controller idle, takes request
  input  wire logic [2:0]  req_op,              // operation code
  input  wire logic [18:0] req_addr,            // byte or sector address
  input  wire logic [7:0]  req_data,            // write data
  output logic             done,                // one-cycle completion pulse
  output logic             fail,                // with done: operation failed
  output logic [7:0]       rd_data,             // read result
  output logic             flash_busy,          // flash operation running
  output logic [18:0]      mem_addr,            // address pins
  output logic [7:0]       dq_out,              // data pins, driven value
  output logic             dq_oe,               // data pins driven by host
  input  wire logic [7:0]  dq_in,               // data pins, sampled value
  output logic             write_strobe_n,      // write strobe
  output logic             output_enable_n,     // output enable
  output logic             flash_bank_select_n, // flash bank select
  output logic             sram_bank_select_n   // sram bank select
);
  typedef enum logic [6:0] {
    ST_IDLE  = 7'b0000001,
    ST_SETUP = 7'b0000010,
    ST_WLOW  = 7'b0000100,
    ST_WHIGH = 7'b0001000,
    ST_RLOW  = 7'b0010000,
    ST_RDONE = 7'b0100000,
    ST_POLL  = 7'b1000000
  } state_t;

  state_t      state_q;
  logic [2:0]  op_q;
  logic [18:0] addr_q;
  logic [7:0]  data_q;
  logic [2:0]  step_q;      // current command cycle index
  logic [2:0]  last_q;      // index of final command cycle
  logic [1:0]  pol_cnt_q;   // clock count within the current four-clock poll
  logic [7:0]  prev_q;      // previous status read
  logic [1:0]  conf_q;      // confirmation reads done so far
  logic [31:0] tmo_q;       // program watchdog
  logic        busy_q;

  // address of command cycle n for the current operation
  function automatic logic [18:0] cyc_addr(input logic [2:0] n, input logic [2:0] op,
                                           input logic [18:0] a);
    logic [18:0] r;
    r = UNLOCK_ADDR_A;
    case (n)
      3'h1, 3'h4: r = UNLOCK_ADDR_B;
      3'h3: r = (op == OP_PROGRAM) ? a : UNLOCK_ADDR_A;
      3'h5: r = (op == OP_SECTOR_ER)
              ? {a[18 -: SECTOR_W], {SECTOR_LSB{1'b0}}} : UNLOCK_ADDR_A;
      default: r = UNLOCK_ADDR_A;
    endcase
    return r;
  endfunction : cyc_addr

  // data of command cycle n for the current operation
  function automatic logic [7:0] cyc_data(input logic [2:0] n, input logic [2:0] op,
                                          input logic [7:0] d);
    logic [7:0] r;
    r = UNLOCK_DATA_A;
    case (n)
      3'h0, 3'h3: r = (op == OP_PROGRAM) && (n == 3'h3) ? d : UNLOCK_DATA_A;
      3'h1, 3'h4: r = UNLOCK_DATA_B;
      3'h2: case (op)
              OP_PROGRAM:  r = CMD_PROGRAM;
              OP_ID_ENTRY: r = CMD_ID_ENTRY;
              OP_ID_EXIT:  r = CMD_ID_EXIT;
              default:     r = CMD_ERASE_PRE;
            endcase
      3'h5: r = (op == OP_SECTOR_ER) ? CMD_SECTOR_ER : CMD_BANK_ER;
      default: r = UNLOCK_DATA_A;
    endcase
    return r;
  endfunction : cyc_data

  logic is_sram;
  logic is_read;
  logic in_cmd;
  assign is_sram = (op_q == OP_SRAM_RD) || (op_q == OP_SRAM_WR);
  assign is_read = (op_q == OP_READ) || (op_q == OP_SRAM_RD);
  assign in_cmd  = !is_read && (op_q != OP_SRAM_WR);

  // handshake: flash requests wait for busy to clear and sram requests do not, though busy is high only in the poll state
  assign req_ready = (state_q == ST_IDLE) &&
                     (!busy_q || req_op == OP_SRAM_RD || req_op == OP_SRAM_WR);
  assign flash_busy = busy_q;

  // main sequencer: one full bus cycle per step, write strobe 100 ns wide, output enable 200 ns
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      state_q   <= ST_IDLE;
      op_q      <= OP_READ;
      addr_q    <= 19'h00000;
      data_q    <= 8'h00;
      step_q    <= 3'h0;
      last_q    <= 3'h0;
      pol_cnt_q <= 2'h0;
      prev_q    <= 8'h00;
      conf_q    <= 2'h0;
      tmo_q     <= 32'h0;
      busy_q    <= 1'b0;
      done      <= 1'b0;
      fail      <= 1'b0;
      rd_data   <= 8'h00;
    end
    else if (ce)
    begin
      done <= 1'b0;
      fail <= 1'b0;
      case (state_q)
        ST_IDLE:
        begin
          if (req_valid && req_ready)
          begin
            op_q   <= req_op;
            addr_q <= req_addr;
            data_q <= req_data;
            step_q <= 3'h0;
            case (req_op)
              OP_PROGRAM:              last_q <= 3'h3;
              OP_SECTOR_ER, OP_BANK_ER: last_q <= 3'h5;
              OP_ID_ENTRY, OP_ID_EXIT: last_q <= 3'h2;
              default:                 last_q <= 3'h0;
            endcase
            state_q <= ST_SETUP;
          end
        end
        ST_SETUP:
          state_q <= is_read ? ST_RLOW : ST_WLOW;
        ST_WLOW:
          state_q <= ST_WHIGH;
        ST_WHIGH:
        begin
          if (in_cmd && step_q != last_q)
          begin
            step_q  <= step_q + 3'h1;
            state_q <= ST_SETUP;
          end
          else if (op_q == OP_PROGRAM || op_q == OP_SECTOR_ER || op_q == OP_BANK_ER)
          begin
            busy_q    <= 1'b1;
            tmo_q     <= 32'h0;
            pol_cnt_q <= 2'h0;
            conf_q    <= 2'h0;
            state_q   <= ST_POLL;
          end
          else
          begin
            done    <= 1'b1;
            state_q <= ST_IDLE;
          end
        end
        ST_RLOW:
          state_q <= ST_RDONE;
        ST_RDONE:
        begin
          rd_data <= dq_in;
          done    <= 1'b1;
          state_q <= ST_IDLE;
        end
        ST_POLL:
        begin
          // one poll per four clocks: oe low during counts 1 and 2, bus sampled at the end of count 1
          pol_cnt_q <= pol_cnt_q + 2'h1;
          if (op_q == OP_PROGRAM)
            tmo_q <= tmo_q + 32'h1;
          if (pol_cnt_q == 2'h1)
          begin
            prev_q <= dq_in;
            if (op_q == OP_PROGRAM && tmo_q > 32'(PROG_TIMEOUT))
            begin
              busy_q  <= 1'b0;
              done    <= 1'b1;
              fail    <= 1'b1;
              state_q <= ST_IDLE;
            end
            else if ((dq_in[TOGGLE_BIT] == prev_q[TOGGLE_BIT]) &&
                     (op_q == OP_PROGRAM ? dq_in[POLL_BIT] == data_q[POLL_BIT]
                                         : dq_in[POLL_BIT]))
            begin
              if (conf_q == 2'(CONFIRM_READS))
              begin
                busy_q  <= 1'b0;
                done    <= 1'b1;
                state_q <= ST_IDLE;
              end
              else
                conf_q <= conf_q + 2'h1;
            end
            else
              conf_q <= 2'h0;
          end
        end
        default:
          state_q <= ST_IDLE;
      endcase
    end
  end

  // pin drive: registered from state so strobes are glitch free
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      mem_addr            <= 19'h00000;
      dq_out              <= 8'h00;
      dq_oe               <= 1'b0;
      write_strobe_n      <= 1'b1;
      output_enable_n     <= 1'b1;
      flash_bank_select_n <= 1'b1;
      sram_bank_select_n  <= 1'b1;
    end
    else if (ce)
    begin
      write_strobe_n      <= 1'b1;
      output_enable_n     <= 1'b1;
      flash_bank_select_n <= 1'b1;
      sram_bank_select_n  <= 1'b1;
      dq_oe               <= 1'b0;
      case (state_q)
        ST_SETUP:
        begin
          mem_addr <= in_cmd ? cyc_addr(step_q, op_q, addr_q) : addr_q;
          dq_out   <= in_cmd ? cyc_data(step_q, op_q, data_q) : data_q;
          // only one bank select at a time, avoiding the override case
          flash_bank_select_n <= is_sram;
          sram_bank_select_n  <= !is_sram;
          dq_oe               <= !is_read;
          output_enable_n     <= is_read ? 1'b0 : 1'b1;
        end
        ST_WLOW:
        begin
          flash_bank_select_n <= is_sram;
          sram_bank_select_n  <= !is_sram;
          dq_oe               <= 1'b1;
          write_strobe_n      <= 1'b0;
        end
        ST_WHIGH:
        begin
          flash_bank_select_n <= is_sram;
          sram_bank_select_n  <= !is_sram;
          dq_oe               <= 1'b1;
        end
        ST_RLOW:
        begin
          flash_bank_select_n <= is_sram;
          sram_bank_select_n  <= !is_sram;
          output_enable_n     <= 1'b0;
        end
        ST_POLL:
        begin
          mem_addr            <= addr_q;
          flash_bank_select_n <= 1'b0;
          output_enable_n     <= pol_cnt_q[1];
        end
        default: dq_oe <= 1'b0;
      endcase
    end
  end
endmodule : flash_host

/* flash_host_pkg.sv */
// constants for the combined flash and sram memory host controller
package flash_host_pkg;
  // unlock pattern addresses and data
  localparam logic [18:0] UNLOCK_ADDR_A  = 19'h05555;
  localparam logic [18:0] UNLOCK_ADDR_B  = 19'h02AAA;
  localparam logic [7:0]  UNLOCK_DATA_A  = 8'hAA;
  localparam logic [7:0]  UNLOCK_DATA_B  = 8'h55;
  // command codes carried in the third and sixth cycles
  localparam logic [7:0]  CMD_PROGRAM    = 8'hA0;
  localparam logic [7:0]  CMD_ERASE_PRE  = 8'h80;
  localparam logic [7:0]  CMD_SECTOR_ER  = 8'h30;
  localparam logic [7:0]  CMD_BANK_ER    = 8'h10;
  localparam logic [7:0]  CMD_ID_ENTRY   = 8'h90;
  localparam logic [7:0]  CMD_ID_EXIT    = 8'hF0;
  // identification addresses
  localparam logic [18:0] ID_MAKER_ADDR  = 19'h00000;
  localparam logic [18:0] ID_DEVICE_ADDR = 19'h00001;
  // sector field: address bits 18 down to 12 (4 kbyte sectors)
  localparam int          SECTOR_LSB     = 12;
  localparam int          SECTOR_W       = 7;
  // data bit positions of the status bits
  localparam int          POLL_BIT       = 7;
  localparam int          TOGGLE_BIT     = 6;
  // timing: clock period, least strobe width, program limit
  localparam int          CLK_PERIOD_NS  = 100;
  localparam int          MIN_PULSE_NS   = 5;
  localparam int          PULSE_CYCLES   = (MIN_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int          PROG_MAX_US    = 20;
  localparam int          PROG_MAX_CYC   = (PROG_MAX_US * 1000) / CLK_PERIOD_NS;
  // number of extra confirmation reads
  localparam int          CONFIRM_READS  = 2;
  // operation codes on the user port
  localparam logic [2:0]  OP_READ        = 3'h0;
  localparam logic [2:0]  OP_PROGRAM     = 3'h1;
  localparam logic [2:0]  OP_SECTOR_ER   = 3'h2;
  localparam logic [2:0]  OP_BANK_ER     = 3'h3;
  localparam logic [2:0]  OP_ID_ENTRY    = 3'h4;
  localparam logic [2:0]  OP_ID_EXIT     = 3'h5;
  localparam logic [2:0]  OP_SRAM_RD     = 3'h6;
  localparam logic [2:0]  OP_SRAM_WR     = 3'h7;
endpackage : flash_host_pkg

/* flash_host_sva.sv */
// checker on the pins and user port of the flash host controller
`timescale 1ns/1ps
module flash_host_sva
  import flash_host_pkg::*;
#(
  parameter int PROG_TIMEOUT = 200 // program time limit in cycles
)(
  input wire logic        clk,                 // clock
  input wire logic        rst,                 // reset
  input wire logic [2:0]  req_op,              // op code
  input wire logic        req_ready,           // request taken
  input wire logic        done,                // finish pulse
  input wire logic        fail,                // failure flag
  input wire logic        flash_busy,          // flash running
  input wire logic [18:0] mem_addr,            // address pins
  input wire logic [7:0]  dq_out,              // data driven
  input wire logic        dq_oe,               // data drive enable
  input wire logic        write_strobe_n,      // write strobe
  input wire logic        output_enable_n,     // output enable
  input wire logic        flash_bank_select_n, // flash select
  input wire logic        sram_bank_select_n   // sram select
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  // strobe low for exactly one clock, then high
  sequence s_wr_low;
    !write_strobe_n ##1 write_strobe_n;
  endsequence
  property p_wr_pulse; $fell(write_strobe_n) |-> s_wr_low; endproperty
  a_wr_pulse: assert property (p_wr_pulse) else $error("strobe width");
  property p_wr_quiet; !write_strobe_n |-> output_enable_n && dq_oe; endproperty
  a_wr_quiet: assert property (p_wr_quiet) else $error("write while reading");
  property p_wr_sel; !write_strobe_n |-> !(flash_bank_select_n && sram_bank_select_n); endproperty
  a_wr_sel: assert property (p_wr_sel) else $error("write without bank");
  property p_wr_hold; $fell(write_strobe_n) |=> $stable(mem_addr) && $stable(dq_out); endproperty
  a_wr_hold: assert property (p_wr_hold) else $error("pins moved in write");
  property p_one_bank; !flash_bank_select_n |-> sram_bank_select_n; endproperty
  a_one_bank: assert property (p_one_bank) else $error("both banks");
  property p_refuse; flash_busy && req_op < OP_SRAM_RD |-> !req_ready; endproperty
  a_refuse: assert property (p_refuse) else $error("taken while busy");
  property p_fail; fail |-> done ##1 !done; endproperty
  a_fail: assert property (p_fail) else $error("fail alone");
  property p_rd_oe; !output_enable_n |-> !dq_oe && write_strobe_n; endproperty
  a_rd_oe: assert property (p_rd_oe) else $error("drive while reading");
endmodule : flash_host_sva
bind flash_host flash_host_sva #(.PROG_TIMEOUT(PROG_TIMEOUT)) u_sva (.clk, .rst, .req_op,
  .req_ready, .done, .fail, .flash_busy, .mem_addr, .dq_out, .dq_oe, .write_strobe_n,
  .output_enable_n, .flash_bank_select_n, .sram_bank_select_n);

/* flash_mem_model.sv */
// behavioural flash and sram memory seen on the host pins
`timescale 1ns/1ps
module flash_mem_model
  import flash_host_pkg::*;
#(
  parameter int         ERASE_NS = 20000, // erase time
  parameter logic [7:0] MAKER_ID = 8'h5A, // arbitrary value
  parameter logic [7:0] DEV_ID   = 8'hA5  // arbitrary value
)(
  input  wire logic [18:0] addr,   // address
  input  wire logic [7:0]  din,    // data bus
  input  wire logic        we_n,   // write strobe
  input  wire logic        oe_n,   // output enable
  input  wire logic        fsel_n, // flash select
  input  wire logic        ssel_n, // sram select
  output logic      [7:0]  dout    // read data
);
  logic [7:0]  fl [524288];
  logic [7:0]  sr [131072];
  logic [18:0] a_q;
  logic [7:0]  pd_q;
  logic        id_q = 1'h0, era_q = 1'h0, tog_q = 1'h0;
  int          step = 0, prog_ns = 3000;
  realtime     busy_until = 0, fall_t = 0;
  initial
  begin
    foreach (fl[k]) fl[k] = 8'hFF;
    dout = 8'h00;
  end
  // walk the protected sequence; a cycle that fits nowhere drops it
  task automatic decode(input logic [18:0] a, input logic [7:0] d);
    int s;
    s = step;
    step = 0;
    if (s == 6)
    begin
      fl[a] = d;
      pd_q = d;
      era_q = 1'h0;
      busy_until = $realtime + prog_ns;
    end
    else if (s == 5 && (d == CMD_SECTOR_ER || (d == CMD_BANK_ER && a == UNLOCK_ADDR_A)))
    begin
      foreach (fl[k])
        if (d == CMD_BANK_ER || k[18:12] == a[18:12]) fl[k] = 8'hFF;
      era_q = 1'h1;
      busy_until = $realtime + ERASE_NS;
    end
    else if (s inside {0, 3} && a == UNLOCK_ADDR_A && d == UNLOCK_DATA_A) step = s + 1;
    else if (s inside {1, 4} && a == UNLOCK_ADDR_B && d == UNLOCK_DATA_B) step = s + 1;
    else if (s == 2 && a == UNLOCK_ADDR_A && d == CMD_PROGRAM) step = 6;
    else if (s == 2 && a == UNLOCK_ADDR_A && d == CMD_ERASE_PRE) step = 3;
    else if (s == 2 && a == UNLOCK_ADDR_A && d inside {CMD_ID_ENTRY, CMD_ID_EXIT})
      id_q = d == CMD_ID_ENTRY;
  endtask : decode
  // address taken as the strobe falls
  always @(negedge we_n)
  begin
    a_q = addr;
    fall_t = $realtime;
  end
  // data taken as the strobe rises; short, inhibited or busy flash cycles ignored
  always @(posedge we_n)
    if (!ssel_n && fsel_n) sr[a_q[16:0]] = din;
    else if (!fsel_n && oe_n && $realtime - fall_t >= 5 && $realtime >= busy_until)
      decode(a_q, din);
  // status while busy, ids in id mode, else array or sram
  always @(negedge oe_n)
  begin
    #1;
    if (!fsel_n && $realtime < busy_until)
    begin
      tog_q = ~tog_q;
      dout = {~era_q & ~pd_q[7], tog_q, 6'h00};
    end
    else if (!fsel_n)
      dout = id_q && addr < 19'h00002 ? (addr[0] ? DEV_ID : MAKER_ID) : fl[addr];
    else if (!ssel_n)
      dout = sr[addr[16:0]];
  end
  // released bus shows the inverse of the last value
  always @(posedge oe_n) dout = ~dout;
endmodule : flash_mem_model

/* testbench.sv */
// self-checking testbench for the flash host controller
`timescale 1ns/1ps
module testbench;
  import flash_host_pkg::*;
  localparam logic [7:0] MAKER_ID = 8'h5A; // arbitrary value
  localparam logic [7:0] DEV_ID   = 8'hA5; // arbitrary value
  logic        clk = 1'h0, rst = 1'h1, ce = 1'h1, req_valid = 1'h0;
  logic        req_ready, done, fail, flash_busy, dq_oe, write_strobe_n, output_enable_n;
  logic        flash_bank_select_n, sram_bank_select_n;
  logic [2:0]  req_op = OP_READ;
  logic [18:0] req_addr = 19'h00000, mem_addr, pa;
  logic [7:0]  req_data = 8'h00, rd_data, dq_out, mem_q, bus, lq = 8'h3C, pd;
  logic [9:0]  exp_q [$];
  int          fails = 0, compares = 0, issued = 0, seen = 0, cyc = 0;
  assign bus = dq_oe ? dq_out : mem_q;
  flash_host #(.PROG_TIMEOUT(50)) u_dut (.clk, .rst, .ce, .req_valid, .req_ready, .req_op,
    .req_addr, .req_data, .done, .fail, .rd_data, .flash_busy, .mem_addr, .dq_out, .dq_oe,
    .dq_in(bus), .write_strobe_n, .output_enable_n, .flash_bank_select_n, .sram_bank_select_n);
  flash_mem_model #(.MAKER_ID(MAKER_ID), .DEV_ID(DEV_ID)) u_mem (.addr(mem_addr), .din(bus),
    .we_n(write_strobe_n), .oe_n(output_enable_n), .fsel_n(flash_bank_select_n),
    .ssel_n(sram_bank_select_n), .dout(mem_q));
  initial forever #50 clk = ~clk;
  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction : lfsr
  task automatic cmp(input string what, input logic [7:0] e, input logic [7:0] g);
    compares++;
    if (g !== e)
    begin
      fails++;
      $display("[ERR] %s expected %h seen %h", what, e, g);
    end
  endtask : cmp
  task automatic tally_and_finish();
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : tally_and_finish
  // hold a request until taken; note the expected {fail, check, data}
  task automatic issue(input logic [2:0] op, input logic [18:0] a, input logic [7:0] d,
    input logic [9:0] e);
    @(negedge clk);
    req_op = op;
    req_addr = a;
    req_data = d;
    req_valid = 1'h1;
    exp_q.push_back(e);
    issued++;
    #1;
    while (req_ready !== 1'h1) @(negedge clk);
    @(negedge clk);
    req_valid = 1'h0;
  endtask : issue
  task automatic sync(input string name);
    while (seen != issued) @(negedge clk);
    $display("test %s done", name);
  endtask : sync
  // compare each result against the oldest note
  always @(posedge clk)
    if (done === 1'h1 && exp_q.size() > 0)
    begin
      cmp("fail", {7'h00, exp_q[0][9]}, {7'h00, fail});
      if (exp_q[0][8]) cmp("rd_data", exp_q[0][7:0], rd_data);
      void'(exp_q.pop_front());
      seen++;
    end
  // cut a hang short
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      fails++;
      tally_and_finish();
    end
  end
  initial
  begin
    repeat (16) @(negedge clk);
    rst = 1'h0;
    repeat (3)
    begin
      lq = lfsr(lq);
      issue(OP_READ, {lq, lq[2:0], lq}, 8'h00, {2'h1, 8'hFF});
    end
    sync("erased_read");
    pa = {lq[6:0], 4'h3, lq};
    pd = lfsr(lq);
    issue(OP_PROGRAM, pa, pd, 10'h000);
    issue(OP_SRAM_WR, pa & 19'h1FFFF, ~pd, 10'h000);
    sync("program");
    issue(OP_SRAM_RD, pa & 19'h1FFFF, 8'h00, {2'h1, ~pd});
    issue(OP_READ, pa, 8'h00, {2'h1, pd});
    issue(OP_PROGRAM, pa ^ 19'h01000, ~pd, 10'h000);
    issue(OP_SECTOR_ER, pa, 8'h00, 10'h000);
    issue(OP_READ, pa, 8'h00, {2'h1, 8'hFF});
    issue(OP_READ, pa ^ 19'h01000, 8'h00, {2'h1, ~pd});
    sync("sector_erase");
    issue(OP_ID_ENTRY, 19'h00000, 8'h00, 10'h000);
    issue(OP_READ, ID_MAKER_ADDR, 8'h00, {2'h1, MAKER_ID});
    issue(OP_READ, ID_DEVICE_ADDR, 8'h00, {2'h1, DEV_ID});
    issue(OP_ID_EXIT, 19'h00000, 8'h00, 10'h000);
    issue(OP_READ, ID_DEVICE_ADDR, 8'h00, {2'h1, 8'hFF});
    sync("identification");
    issue(OP_BANK_ER, 19'h00000, 8'h00, 10'h000);
    // freeze the controller in mid-poll; the erase must still finish
    repeat (40) @(negedge clk);
    ce = 1'h0;
    repeat (8) @(negedge clk);
    ce = 1'h1;
    issue(OP_READ, pa ^ 19'h01000, 8'h00, {2'h1, 8'hFF});
    sync("bank_erase");
    u_mem.prog_ns = 9000;
    issue(OP_PROGRAM, pa, pd, {2'h2, 8'h00});
    sync("program_timeout");
    tally_and_finish();
  end
endmodule : testbench
